/* File: include/rcs_pkg.sv */
// constants for the reset-cause and debug force-reset block
// assumes one 50 MHz bus clock and 8-bit register data
package rcs_pkg;
   // clock and reset stretch timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int RST_HOLD_NS = 640;
   // least time, so round up to whole cycles
   localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CNT_W = 6;

   // register width and field positions of reset_cause_status
   localparam int REG_W = 8;
   localparam int POR_BIT = 7;
   localparam int PIN_BIT = 6;
   localparam int WDOG_BIT = 5;
   localparam int ILLEGAL_OPCODE_FLAG_BIT = 4;
   localparam int ILLEGAL_ADDRESS_FLAG_BIT = 3;
   localparam int LVD_BIT = 1;

   // host_forced_reset_bit position in debug_force_reset_ctrl
   localparam int FORCE_BIT = 0;

   // values and reset states
   localparam logic [7:0] SVC_FIRST = 8'h55;
   localparam logic [7:0] SVC_SECOND = 8'haa;
   localparam logic [7:0] POR_FLAGS = 8'h82;
   localparam logic [7:0] FLAGS_NONE = 8'h00;
   localparam logic [7:0] DFR_READ = 8'h00;

   // service detector and reset sequencer states
   typedef enum logic {RCS_IDLE, RCS_ARMED} rcs_svc_t;
   typedef enum logic {RCS_RUN, RCS_HOLD} rcs_seq_t;
endpackage

/* File: verification/rcs_host_model.sv */
// cpu software and serial debug host driving the register strobes
// assumes calls come only while the chip is out of reset
`timescale 1ns/1ps
module rcs_host_model (
   // clock
   input wire logic ref_clk_i,
   // strobes towards the block
   output logic cause_sel_o,
   output logic force_sel_o,
   output logic bus_wr_o,
   output logic bus_rd_o,
   output logic debug_cmd_o,
   output logic [7:0] bus_wdata_o,
   // read data back
   input wire logic [7:0] bus_rdata_i
);
   // quiet bus at time zero
   initial begin
      {cause_sel_o, force_sel_o, bus_wr_o, bus_rd_o, debug_cmd_o} = 5'h00;
      bus_wdata_o = 8'h00;
   end
   // release; data inverted so a stale value never looks valid
   task automatic idle();
      {cause_sel_o, force_sel_o, bus_wr_o, bus_rd_o, debug_cmd_o} <= 5'h00;
      bus_wdata_o <= ~bus_wdata_o;
   endtask
   // one-cycle write; frc picks the force register, dbg marks a serial command
   task automatic wr(input logic frc, input logic dbg, input logic [7:0] d);
      @(posedge ref_clk_i);
      {cause_sel_o, force_sel_o, bus_wr_o} <= {~frc, frc, 1'b1};
      debug_cmd_o <= dbg;
      bus_wdata_o <= d;
      @(posedge ref_clk_i);
      idle();
   endtask
   // one-cycle read, data taken once the registered answer has landed
   task automatic rd(input logic frc, output logic [7:0] q);
      @(posedge ref_clk_i);
      {cause_sel_o, force_sel_o, bus_rd_o} <= {~frc, frc, 1'b1};
      @(posedge ref_clk_i);
      idle();
      #1 q = bus_rdata_i;
   endtask
   // two-value service, one idle cycle between the first and the second value
   task automatic svc();
      wr(1'b0, 1'b0, 8'h55);
      wr(1'b0, 1'b0, 8'haa);
   endtask
endmodule // rcs_host_model

/* File: verification/rcs_reset_cause_bench.sv */
// self-checking bench for the reset-cause block
// assumes the host model drives the register strobes
`timescale 1ns/1ps
module rcs_reset_cause_bench;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cause_sel, force_sel, bus_wr, bus_rd, debug_cmd, sys_reset, wdog_clear;
   logic [7:0] wdata, rdata, flags_o, q;
   logic [6:0] src = 7'h00; // pin, timeout, opcode, stop, background_instruction, address, trip
   logic [5:0] cfg = 6'h2f; // wd_en, win_mode, win_open, stop_en, background_instruction_en, lvr_en
   int err_count = 0;
   int n_tests = 0;
   // 50 MHz clock
   always #10 ref_clk_i = ~ref_clk_i;
   // short hold keeps the run brief
   rcs_reset_cause #(.HOLD_CYC(3)) i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .cause_sel_i(cause_sel), .force_sel_i(force_sel), .bus_wr_i(bus_wr),
      .bus_rd_i(bus_rd), .debug_cmd_i(debug_cmd), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
      .ext_reset_n_i(~src[6]), .wdog_timeout_i(src[5]), .unimpl_opcode_i(src[4]),
      .stop_exec_i(src[3]), .background_instruction_exec_i(src[2]), .illegal_addr_i(src[1]),
      .low_voltage_trip_i(src[0]), .watchdog_enable_setting_i(cfg[5]),
      .watchdog_window_mode_i(cfg[4]), .window_open_i(cfg[3]),
      .stop_enable_setting_i(cfg[2]), .background_mode_enable_i(cfg[1]),
      .low_voltage_reset_enable_i(cfg[0]), .sys_reset_o(sys_reset),
      .wdog_clear_o(wdog_clear), .reset_cause_status_o(flags_o));
   rcs_host_model i_host (.ref_clk_i(ref_clk_i), .cause_sel_o(cause_sel),
      .force_sel_o(force_sel), .bus_wr_o(bus_wr), .bus_rd_o(bus_rd),
      .debug_cmd_o(debug_cmd), .bus_wdata_o(wdata), .bus_rdata_i(rdata));
   // compare and count
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // verdict and stop
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // bounded wait for the chip to run again
   task automatic wait_run();
      for (int i = 0; i < 40 && sys_reset !== 1'b0; i++) begin
         @(posedge ref_clk_i);
         #1;
      end
      if (sys_reset !== 1'b0) begin
         err_count++;
         end_sim();
      end
   endtask
   // outcome 1 ns after the taking edge
   task automatic post(input logic r, input logic c, input logic [7:0] exp);
      #1;
      chk("sys_reset", {7'h00, sys_reset}, {7'h00, r});
      chk("wdog_clear", {7'h00, wdog_clear}, {7'h00, c});
      chk("flags", flags_o, exp);
      wait_run();
   endtask
   // one-cycle source pulse
   task automatic hit(input logic [6:0] s, input logic r, input logic [7:0] exp);
      @(posedge ref_clk_i);
      src <= s;
      @(posedge ref_clk_i);
      src <= 7'h00;
      post(r, 1'b0, exp);
   endtask
   // settings change on a clock edge
   task automatic set_cfg(input logic [5:0] v);
      @(posedge ref_clk_i);
      cfg <= v;
   endtask
   // hang guard
   initial begin
      #200us;
      err_count++;
      end_sim();
   end
   // main sequence
   initial begin
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      wait_run();
      chk("por flags", flags_o, 8'h82);
      i_host.rd(1'b0, q);
      chk("cause read", q, 8'h82);
      i_host.svc();
      post(1'b0, 1'b1, 8'h82);
      i_host.wr(1'b0, 1'b0, 8'h55);
      i_host.svc();
      post(1'b0, 1'b1, 8'h82);
      i_host.wr(1'b0, 1'b0, 8'haa);
      post(1'b0, 1'b0, 8'h82);
      i_host.wr(1'b0, 1'b0, 8'h12);
      post(1'b1, 1'b0, 8'h20);
      $display("test service done");
      // watchdog off: no resets, no clears
      set_cfg(6'h0f);
      i_host.wr(1'b0, 1'b0, 8'h12);
      post(1'b0, 1'b0, 8'h20);
      i_host.svc();
      post(1'b0, 1'b0, 8'h20);
      hit(7'h20, 1'b0, 8'h20);
      set_cfg(6'h2f);
      // each source and a pair of them
      hit(7'h40, 1'b1, 8'h40);
      hit(7'h20, 1'b1, 8'h20);
      hit(7'h10, 1'b1, 8'h10);
      hit(7'h02, 1'b1, 8'h08);
      hit(7'h42, 1'b1, 8'h48);
      hit(7'h08, 1'b0, 8'h48);
      hit(7'h04, 1'b0, 8'h48);
      set_cfg(6'h29);
      hit(7'h08, 1'b1, 8'h10);
      hit(7'h04, 1'b1, 8'h10);
      set_cfg(6'h2e);
      hit(7'h01, 1'b0, 8'h10);
      set_cfg(6'h2f);
      hit(7'h01, 1'b1, 8'h02);
      $display("test sources done");
      // force register
      i_host.wr(1'b1, 1'b0, 8'h01);
      post(1'b0, 1'b0, 8'h02);
      i_host.rd(1'b1, q);
      chk("force read", q, 8'h00);
      i_host.wr(1'b1, 1'b1, 8'h01);
      post(1'b1, 1'b0, 8'h00);
      $display("test force done");
      // window mode: early write resets, late service clears
      set_cfg(6'h37);
      i_host.wr(1'b0, 1'b0, 8'h55);
      post(1'b1, 1'b0, 8'h20);
      set_cfg(6'h3f);
      i_host.svc();
      post(1'b0, 1'b1, 8'h20);
      // second power-on, then a trip keeps the power-on bit
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      @(posedge ref_clk_i);
      rst_i <= 1'b0;
      wait_run();
      hit(7'h01, 1'b1, 8'h82);
      $display("test window done");
      end_sim();
   end
endmodule // rcs_reset_cause_bench

/* File: verilog/rcs_reset_cause.sv */
// reset-cause capture, watchdog service decode and debug force reset
// assumes cpu strobes are one cycle and synchronous to ref_clk_i,
// and rst_i is the power-on reset of the whole chip
// How it works
// - cause register is read-only, loaded only when a chip reset begins
// - debug-forced reset without a same-cycle enabled low-voltage trip leaves every cause flag cleared
// - with watchdog on, writing any value but 55h or AAh resets
// - 55h then AAh clears watchdog counter, flags stay unchanged
// - power-on sets power-on flag bit 7 and low-voltage flag bit 1
// - other resets set active pin/watchdog/opcode/address flags, clear the rest
// - external pin low level sets flag bit 6
// - watchdog timeout sets bit 5; ignored while watchdog disabled
// - illegal or unimplemented instruction sets flag bit 4
// - stop illegal when stop disabled, background when background mode disabled
// - access to unimplemented address sets flag bit 3
// - enabled low-voltage trip reset sets bit 1, power-on bit kept
// - user writes to force register ignored, reads return zero
// - debug host writing 1 to force bit resets the chip
// - window mode: any cause-register write in first 75% resets
`timescale 1ns/1ps
module rcs_reset_cause #(
   parameter int HOLD_CYC = rcs_pkg::RST_HOLD_CYC
) (
   // clock and power-on reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // register access
   input wire logic cause_sel_i,
   input wire logic force_sel_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic debug_cmd_i,
   input wire logic [7:0] bus_wdata_i,
   output logic [7:0] bus_rdata_o,
   // reset sources
   input wire logic ext_reset_n_i,
   input wire logic wdog_timeout_i,
   input wire logic unimpl_opcode_i,
   input wire logic stop_exec_i,
   input wire logic background_instruction_exec_i,
   input wire logic illegal_addr_i,
   input wire logic low_voltage_trip_i,
   // system settings
   input wire logic watchdog_enable_setting_i,
   input wire logic watchdog_window_mode_i,
   input wire logic window_open_i,
   input wire logic stop_enable_setting_i,
   input wire logic background_mode_enable_i,
   input wire logic low_voltage_reset_enable_i,
   // outputs
   output logic sys_reset_o,
   output logic wdog_clear_o,
   output logic [7:0] reset_cause_status_o
);
   rcs_pkg::rcs_seq_t state_reg, state_next;
   logic [rcs_pkg::HOLD_CNT_W-1:0] cnt_reg, cnt_next;
   logic [7:0] cause_reg, cause_next;
   logic [7:0] rdata_reg, rdata_next;
   logic wclr_reg, wclr_next;
   logic running, cause_wr, svc_clear, svc_bad;
   logic pin_act, wdog_act, illegal_opcode_flag_act, illegal_address_flag_act, lv_act, force_act, entry;
   logic hold_done;

   assign running = (state_reg == rcs_pkg::RCS_RUN);
   assign cause_wr = running && bus_wr_i && cause_sel_i;

   rcs_svc_detect u_svc (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .wr_i(cause_wr),
      .data_i(bus_wdata_i),
      .flush_i(!running),
      .wdog_en_i(watchdog_enable_setting_i),
      .window_mode_i(watchdog_window_mode_i),
      .window_open_i(window_open_i),
      .clear_o(svc_clear),
      .bad_o(svc_bad)
   );

   // source qualification; a bad service write counts as a watchdog reset
   always_comb begin
      pin_act = !ext_reset_n_i;
      wdog_act = (wdog_timeout_i && watchdog_enable_setting_i) || svc_bad;
      illegal_opcode_flag_act = unimpl_opcode_i || (stop_exec_i && !stop_enable_setting_i)
         || (background_instruction_exec_i && !background_mode_enable_i);
      illegal_address_flag_act = illegal_addr_i;
      lv_act = low_voltage_trip_i && low_voltage_reset_enable_i;
      // only a serial debug command may set the force bit
      force_act = bus_wr_i && force_sel_i && debug_cmd_i
         && bus_wdata_i[rcs_pkg::FORCE_BIT];
      entry = running && (pin_act || wdog_act || illegal_opcode_flag_act || illegal_address_flag_act || lv_act
         || force_act);
   end

   // cause capture at reset entry, low voltage first, then debug force
   always_comb begin
      cause_next = cause_reg;
      if (entry) begin
         if (lv_act) begin
            cause_next = rcs_pkg::FLAGS_NONE;
            cause_next[rcs_pkg::POR_BIT] = cause_reg[rcs_pkg::POR_BIT];
            cause_next[rcs_pkg::LVD_BIT] = 1'b1;
         end else if (force_act) begin
            cause_next = rcs_pkg::FLAGS_NONE;
         end else begin
            cause_next = rcs_pkg::FLAGS_NONE;
            cause_next[rcs_pkg::PIN_BIT] = pin_act;
            cause_next[rcs_pkg::WDOG_BIT] = wdog_act;
            cause_next[rcs_pkg::ILLEGAL_OPCODE_FLAG_BIT] = illegal_opcode_flag_act;
            cause_next[rcs_pkg::ILLEGAL_ADDRESS_FLAG_BIT] = illegal_address_flag_act;
         end
      end
   end

   // reset stretch: held while pin is low or an enabled low-voltage trip persists
   always_comb begin
      hold_done = (cnt_reg >= rcs_pkg::HOLD_CNT_W'(HOLD_CYC - 1));
      state_next = state_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         rcs_pkg::RCS_RUN: begin
            cnt_next = '0;
            if (entry) begin
               state_next = rcs_pkg::RCS_HOLD;
            end
         end
         rcs_pkg::RCS_HOLD: begin
            if (!hold_done) begin
               cnt_next = cnt_reg + 1'b1;
            end else if (!pin_act && !lv_act) begin
               state_next = rcs_pkg::RCS_RUN;
            end
         end
      endcase
   end

   // read data and service pulse; force register always reads zero
   always_comb begin
      rdata_next = rdata_reg;
      if (bus_rd_i && cause_sel_i) begin
         rdata_next = cause_reg;
      end else if (bus_rd_i && force_sel_i) begin
         rdata_next = rcs_pkg::DFR_READ;
      end
      wclr_next = svc_clear;
   end

   // power-on loads its own flag pattern
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= rcs_pkg::RCS_HOLD;
         cnt_reg <= '0;
         cause_reg <= rcs_pkg::POR_FLAGS;
         rdata_reg <= '0;
         wclr_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         cause_reg <= cause_next;
         rdata_reg <= rdata_next;
         wclr_reg <= wclr_next;
      end
   end

   assign sys_reset_o = !running;
   assign wdog_clear_o = wclr_reg;
   assign bus_rdata_o = rdata_reg;
   assign reset_cause_status_o = cause_reg;

   a_flags_only_entry: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !entry |=> $stable(cause_reg))
      else $error("cause flags changed outside reset entry");
   a_force_clears_flags: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      entry && force_act && !lv_act |=> (cause_reg == rcs_pkg::FLAGS_NONE) && sys_reset_o)
      else $error("forced reset left flags set");
   a_bad_write_resets: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cause_wr && watchdog_enable_setting_i && !lv_act && !force_act
      && (bus_wdata_i != rcs_pkg::SVC_FIRST) && (bus_wdata_i != rcs_pkg::SVC_SECOND)
      |=> sys_reset_o && cause_reg[rcs_pkg::WDOG_BIT])
      else $error("bad service value did not reset");
   a_service_keeps_flags: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      svc_clear && !entry |=> wdog_clear_o && $stable(cause_reg) && !sys_reset_o)
      else $error("service sequence mishandled");
   a_pin_sets_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      running && !ext_reset_n_i && !lv_act && !force_act |=> cause_reg[rcs_pkg::PIN_BIT])
      else $error("pin reset flag missing");
   a_wdog_blocked: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      running && !watchdog_enable_setting_i && ext_reset_n_i && !illegal_opcode_flag_act && !illegal_address_flag_act
      && !lv_act && !force_act |=> !sys_reset_o)
      else $error("watchdog reset while disabled");
   a_stop_illegal: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      running && stop_exec_i && !stop_enable_setting_i && !lv_act && !force_act
      |=> sys_reset_o && cause_reg[rcs_pkg::ILLEGAL_OPCODE_FLAG_BIT])
      else $error("disabled stop did not reset");
   a_addr_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      running && illegal_addr_i && !lv_act && !force_act |=> cause_reg[rcs_pkg::ILLEGAL_ADDRESS_FLAG_BIT])
      else $error("illegal address flag missing");
   a_force_reads_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      bus_rd_i && force_sel_i && !cause_sel_i |=> bus_rdata_o == rcs_pkg::DFR_READ)
      else $error("force register read not zero");
   a_user_force_ignored: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      running && bus_wr_i && force_sel_i && !debug_cmd_i && !cause_sel_i && ext_reset_n_i
      && !wdog_timeout_i && !illegal_opcode_flag_act && !illegal_address_flag_act && !lv_act |=> !sys_reset_o)
      else $error("user write forced a reset");
   a_early_window_resets: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cause_wr && watchdog_enable_setting_i && watchdog_window_mode_i && !window_open_i
      |=> sys_reset_o ##1 sys_reset_o)
      else $error("early window write did not reset");
endmodule // rcs_reset_cause

/* File: verilog/rcs_svc_detect.sv */
// watchdog service sequence detector on the reset-cause register address
// assumes wr_i is a one-cycle write strobe, taken only while the chip runs
`timescale 1ns/1ps
module rcs_svc_detect (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // write strobe and data
   input wire logic wr_i,
   input wire logic [7:0] data_i,
   input wire logic flush_i,
   // watchdog settings and window state
   input wire logic wdog_en_i,
   input wire logic window_mode_i,
   input wire logic window_open_i,
   // results, combinational pulses
   output logic clear_o,
   output logic bad_o
);
   rcs_pkg::rcs_svc_t state_reg, state_next;
   logic val_ok;
   logic too_early;
   logic [7:0] prev_wr_reg, prev_wr_next;

   // value and window checks
   always_comb begin
      val_ok = (data_i == rcs_pkg::SVC_FIRST) || (data_i == rcs_pkg::SVC_SECOND);
      too_early = window_mode_i && !window_open_i;
      bad_o = wr_i && wdog_en_i && (!val_ok || too_early);
      clear_o = wr_i && wdog_en_i && !bad_o && (state_reg == rcs_pkg::RCS_ARMED)
         && (data_i == rcs_pkg::SVC_SECOND);
   end

   // any write breaks the pair unless it is the first value
   always_comb begin
      state_next = state_reg;
      if (flush_i) begin
         state_next = rcs_pkg::RCS_IDLE;
      end else if (wr_i) begin
         state_next = (data_i == rcs_pkg::SVC_FIRST) ? rcs_pkg::RCS_ARMED
            : rcs_pkg::RCS_IDLE;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= rcs_pkg::RCS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // shadow of the last value written, kept apart from the state so the check is independent
   always_comb begin
      prev_wr_next = prev_wr_reg;
      if (flush_i) begin
         prev_wr_next = '0;
      end else if (wr_i) begin
         prev_wr_next = data_i;
      end
   end

   // idle cycles between the two writes are legal, so track writes, not cycles
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         prev_wr_reg <= '0;
      end else begin
         prev_wr_reg <= prev_wr_next;
      end
   end

   // a clear needs the first value on the previous write to this address
   a_clear_needs_pair: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      clear_o |-> (prev_wr_reg == rcs_pkg::SVC_FIRST) && (data_i == rcs_pkg::SVC_SECOND))
      else $error("service clear without preceding first value");
endmodule // rcs_svc_detect
